// ===== pkg/ccpw_defs.svh
// Register offsets, field positions, reset values and timing counts of the unit
// Operation
// - Trigger match resets timer, starts conversion
// - Trigger mode leaves pin to port
// - Trigger asserts in same clock as match
// - Timer reset at next timer clock edge
// - Trigger never sets timer overflow flag
// - Removed match cancels pending timer reset
// - PWM output with up to ten bits
// - Period is (limit+1)*4*osc*prescale
// - Period match clears timer, sets pin unless duty is zero, latches
// - Duty is low register then bits 5:4
// - Duty writes apply at next period match
// - High duty buffer read-only during PWM
// - Duty double buffered, hidden 2-bit latch
// - Time base extends timer by two bits
// - Time base equal duty drives pin low
// - High time is duty*osc*prescale
// - Duty above period leaves pin unchanged
// - Resolution is log2 of 4*(limit+1)
// - Prescale 1, 4 or 16, no postscaler
// - Trigger match raises unit interrupt flag
`ifndef CCPW_DEFS_SVH
`define CCPW_DEFS_SVH
`define CCPW_OFF_DUTY_LOW    8'h00
`define CCPW_OFF_DUTY_HIGH   8'h04
`define CCPW_OFF_CONTROL     8'h08
`define CCPW_OFF_IRQ_EN      8'h0c
`define CCPW_OFF_IRQ_FLAGS   8'h10
`define CCPW_OFF_PERIOD      8'h14
`define CCPW_OFF_WT_LOW      8'h18
`define CCPW_OFF_WT_HIGH     8'h1c
`define CCPW_OFF_PT_COUNT    8'h20
`define CCPW_OFF_PT_CONTROL  8'h24
`define CCPW_OFF_AUX         8'h28
`define CCPW_NUM_REGS        11
`define CCPW_RST_CONTROL     8'h00
`define CCPW_RST_PERIOD      8'hff
`define CCPW_RST_PT_COUNT    8'h00
`define CCPW_MODE_SEVT       4'hb
`define CCPW_FLAG_OVF        0
`define CCPW_FLAG_PT         1
`define CCPW_FLAG_UNIT       2
`define CCPW_FLAG_MASK       8'h07
`define CCPW_PT_ON_BIT       2
`define CCPW_AUX_WT_ON       0
`define CCPW_AUX_CONV_EN     1
`define CCPW_PHASES          2'h3
`define CCPW_PRESC_TOP_1     4'h0
`define CCPW_PRESC_TOP_4     4'h3
`define CCPW_PRESC_TOP_16    4'hf
`define CCPW_RESP_OKAY       2'h0
`define CCPW_RESP_SLVERR     2'h2
`endif

// ===== pkg/ccpw_pkg.sv
// Types of the compare trigger and PWM unit
`default_nettype none
package ccpw_pkg;
    typedef struct packed {
        logic [1:0] output_steering_mode;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_field;
    } ccpw_ctrl_s;
    typedef enum logic [1:0] {
        CCPW_PRE_1  = 2'h0,
        CCPW_PRE_4  = 2'h1,
        CCPW_PRE_16 = 2'h2
    } ccpw_presc_e;
endpackage
`default_nettype wire

// ===== rtl/ccpw_unit.sv
// Compare special-event trigger and PWM generator with AXI4-Lite registers
`include "ccpw_defs.svh"
`default_nettype none
module ccpw_unit (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // AXI4-Lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Pin and converter
    output logic             unit_output_pin,
    output logic             pin_drive,
    output logic             special_event,
    output logic             conv_start
);
    ccpw_pkg::ccpw_ctrl_s ctrl_reg;
    logic [7:0]  duty_low_reg;
    logic [7:0]  duty_high_reg;
    logic [1:0]  duty_latch_reg;
    logic [7:0]  irq_en_reg;
    logic [7:0]  irq_flags_reg;
    logic [7:0]  period_limit_reg;
    logic [7:0]  wt_low_reg;
    logic [7:0]  wt_high_reg;
    logic [7:0]  pt_count_reg;
    logic [7:0]  pt_ctrl_reg;
    logic [7:0]  aux_reg;
    logic [1:0]  phase_reg;
    logic [3:0]  presc_reg;
    logic        match_d_reg;
    logic        conv_reg;
    logic        pin_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // One-hot register select, shared by the write and read paths
    function automatic logic [`CCPW_NUM_REGS-1:0] reg_sel(input logic [7:0] a);
        reg_sel = '0;
        case (a)
            `CCPW_OFF_DUTY_LOW:   reg_sel[0] = 1'b1;
            `CCPW_OFF_DUTY_HIGH:  reg_sel[1] = 1'b1;
            `CCPW_OFF_CONTROL:    reg_sel[2] = 1'b1;
            `CCPW_OFF_IRQ_EN:     reg_sel[3] = 1'b1;
            `CCPW_OFF_IRQ_FLAGS:  reg_sel[4] = 1'b1;
            `CCPW_OFF_PERIOD:     reg_sel[5] = 1'b1;
            `CCPW_OFF_WT_LOW:     reg_sel[6] = 1'b1;
            `CCPW_OFF_WT_HIGH:    reg_sel[7] = 1'b1;
            `CCPW_OFF_PT_COUNT:   reg_sel[8] = 1'b1;
            `CCPW_OFF_PT_CONTROL: reg_sel[9] = 1'b1;
            `CCPW_OFF_AUX:        reg_sel[10] = 1'b1;
            default:              reg_sel = '0;
        endcase
    endfunction

    // Write channel: address and data taken together, one write at a time
    logic                     wr_go;
    logic [`CCPW_NUM_REGS-1:0] wsel;
    logic [`CCPW_NUM_REGS-1:0] wr;
    assign wr_go   = awvalid & wvalid & ~bvalid_reg;
    assign awready = wr_go;
    assign wready  = wr_go;
    assign wsel    = reg_sel(awaddr);
    assign wr      = (wr_go & wstrb[0]) ? wsel : '0;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `CCPW_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (|wsel) ? `CCPW_RESP_OKAY : `CCPW_RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Timing: one instruction cycle is four oscillator periods
    logic        instr_tick;
    logic        pwm_mode;
    logic        sevt_mode;
    logic        pt_on;
    logic [3:0]  presc_top;
    logic        pt_tick;
    logic        period_hit;
    logic [1:0]  tb_low;
    logic        tb_step;
    logic        duty_near;
    logic [9:0]  time_base;
    logic [9:0]  duty_next;
    logic [9:0]  duty_buf;
    logic [15:0] wt;
    logic [15:0] cmp_val;
    logic        match;
    logic        wt_run;
    logic        trig_reset;
    logic        wt_ovf;
    logic        sevt_rise;
    assign instr_tick = phase_reg == `CCPW_PHASES;
    assign pwm_mode   = ctrl_reg.unit_mode_field[3:2] == 2'h3;
    assign sevt_mode  = ctrl_reg.unit_mode_field == `CCPW_MODE_SEVT;
    assign pt_on      = pt_ctrl_reg[`CCPW_PT_ON_BIT];

    always_comb begin
        unique case (ccpw_pkg::ccpw_presc_e'(pt_ctrl_reg[1:0]))
            ccpw_pkg::CCPW_PRE_1: presc_top = `CCPW_PRESC_TOP_1;
            ccpw_pkg::CCPW_PRE_4: presc_top = `CCPW_PRESC_TOP_4;
            default:              presc_top = `CCPW_PRESC_TOP_16;
        endcase
    end

    assign pt_tick    = pt_on & instr_tick & (presc_reg == presc_top);
    assign period_hit = pt_tick & (pt_count_reg == period_limit_reg);
    // Low time-base bits are the two count bits just below the period timer, so pulse width scales with prescale
    always_comb begin
        unique case (ccpw_pkg::ccpw_presc_e'(pt_ctrl_reg[1:0]))
            ccpw_pkg::CCPW_PRE_1: begin
                tb_low  = phase_reg;
                tb_step = pt_on | ~instr_tick;
            end
            ccpw_pkg::CCPW_PRE_4: begin
                tb_low  = presc_reg[1:0];
                tb_step = pt_on & instr_tick;
            end
            default: begin
                tb_low  = presc_reg[3:2];
                tb_step = pt_on & instr_tick & (presc_reg[1:0] == 2'h3);
            end
        endcase
    end
    // Clear on the edge that brings the match, else the pulse runs one clock long
    assign duty_near = tb_step & ~wr[8] & ~wr[9] & ((time_base + 10'h001) == duty_buf);
    assign time_base = {pt_count_reg, tb_low};
    assign duty_next = {duty_low_reg, ctrl_reg.duty_low_bits};
    assign duty_buf  = {duty_high_reg, duty_latch_reg};

    // Wide timer and special-event trigger
    assign wt         = {wt_high_reg, wt_low_reg};
    assign cmp_val    = {duty_high_reg, duty_low_reg};
    assign match      = wt == cmp_val;
    assign wt_run     = aux_reg[`CCPW_AUX_WT_ON] & instr_tick & ~wr[6] & ~wr[7];
    // Match is sampled live at the tick, so a rewritten compare value cancels the reset
    assign trig_reset = wt_run & sevt_mode & match;
    assign wt_ovf     = wt_run & ~trig_reset & (wt == 16'hffff);
    assign special_event = sevt_mode & match;
    assign sevt_rise  = special_event & ~match_d_reg;
    assign conv_start = conv_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wt_low_reg  <= 8'h00;
            wt_high_reg <= 8'h00;
        end else if (wr[6] | wr[7]) begin
            if (wr[6]) begin
                wt_low_reg <= wdata[7:0];
            end
            if (wr[7]) begin
                wt_high_reg <= wdata[7:0];
            end
        end else if (trig_reset) begin
            wt_low_reg  <= 8'h00;
            wt_high_reg <= 8'h00;
        end else if (wt_run) begin
            {wt_high_reg, wt_low_reg} <= wt + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            match_d_reg <= 1'b0;
            conv_reg    <= 1'b0;
        end else begin
            match_d_reg <= special_event;
            conv_reg    <= sevt_rise & aux_reg[`CCPW_AUX_CONV_EN];
        end
    end

    // Period timer and prescaler
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            presc_reg <= 4'h0;
        end else if (wr[8] | wr[9]) begin
            presc_reg <= 4'h0;
        end else if (pt_on & instr_tick) begin
            presc_reg <= (presc_reg == presc_top) ? 4'h0 : presc_reg + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pt_count_reg <= `CCPW_RST_PT_COUNT;
        end else if (wr[8]) begin
            pt_count_reg <= wdata[7:0];
        end else if (period_hit) begin
            pt_count_reg <= 8'h00;
        end else if (pt_tick) begin
            pt_count_reg <= pt_count_reg + 8'h01;
        end
    end

    // Duty buffer doubles as the compare high byte outside PWM
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            duty_high_reg  <= 8'h00;
            duty_latch_reg <= 2'h0;
        end else if (pwm_mode) begin
            if (period_hit) begin
                duty_high_reg  <= duty_low_reg;
                duty_latch_reg <= ctrl_reg.duty_low_bits;
            end
        end else if (wr[1]) begin
            duty_high_reg <= wdata[7:0];
        end
    end

    // Output pin; released as soon as PWM is deselected, pulled low at the next clock and held low while PWM stays off
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_reg <= 1'b0;
        end else if (!pwm_mode) begin
            pin_reg <= 1'b0;
        end else if (period_hit) begin
            pin_reg <= duty_next != 10'h000;
        end else if (duty_near || (time_base == duty_buf)) begin
            pin_reg <= 1'b0;
        end
    end
    assign unit_output_pin = pin_reg;
    // Reaches the pin whenever PWM is selected; there is no port direction bit
    assign pin_drive = pwm_mode;

    // Software registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            duty_low_reg     <= 8'h00;
            ctrl_reg         <= `CCPW_RST_CONTROL;
            irq_en_reg       <= 8'h00;
            period_limit_reg <= `CCPW_RST_PERIOD;
            pt_ctrl_reg      <= 8'h00;
            aux_reg          <= 8'h00;
        end else begin
            if (wr[0]) begin
                duty_low_reg <= wdata[7:0];
            end
            if (wr[2]) begin
                ctrl_reg <= wdata[7:0];
            end
            if (wr[3]) begin
                irq_en_reg <= wdata[7:0] & `CCPW_FLAG_MASK;
            end
            if (wr[5]) begin
                period_limit_reg <= wdata[7:0];
            end
            if (wr[9]) begin
                pt_ctrl_reg <= {5'h00, wdata[2:0]};
            end
            if (wr[10]) begin
                aux_reg <= {6'h00, wdata[1:0]};
            end
        end
    end

    // Sticky flags; a hardware set beats a software clear in the same cycle
    logic [7:0] flag_set;
    always_comb begin
        flag_set = 8'h00;
        flag_set[`CCPW_FLAG_OVF]  = wt_ovf;
        flag_set[`CCPW_FLAG_PT]   = period_hit;
        flag_set[`CCPW_FLAG_UNIT] = sevt_rise;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_flags_reg <= 8'h00;
        end else begin
            irq_flags_reg <= ((wr[4] ? wdata[7:0] : irq_flags_reg) | flag_set) & `CCPW_FLAG_MASK;
        end
    end

    // Read channel
    logic [`CCPW_NUM_REGS-1:0] rsel;
    logic [7:0]               rbyte;
    assign rsel    = reg_sel(araddr);
    assign arready = ~rvalid_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    always_comb begin
        rbyte = 8'h00;
        unique case (1'b1)
            rsel[0]:  rbyte = duty_low_reg;
            rsel[1]:  rbyte = duty_high_reg;
            rsel[2]:  rbyte = ctrl_reg;
            rsel[3]:  rbyte = irq_en_reg;
            rsel[4]:  rbyte = irq_flags_reg;
            rsel[5]:  rbyte = period_limit_reg;
            rsel[6]:  rbyte = wt_low_reg;
            rsel[7]:  rbyte = wt_high_reg;
            rsel[8]:  rbyte = pt_count_reg;
            rsel[9]:  rbyte = pt_ctrl_reg;
            rsel[10]: rbyte = aux_reg;
            default:  rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `CCPW_RESP_OKAY;
        end else if (arvalid & ~rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rbyte};
            rresp_reg  <= (|rsel) ? `CCPW_RESP_OKAY : `CCPW_RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Checks
    a_trig_clears_timer: assert property (@(posedge clock) disable iff (!rstn)
        special_event && wt_run |=> wt == 16'h0000)
        else $error("trigger did not clear wide timer");
    a_trig_waits_tick: assert property (@(posedge clock) disable iff (!rstn)
        special_event && !instr_tick && !wr[6] && !wr[7] |=> $stable(wt))
        else $error("wide timer changed before timer clock edge");
    a_cancel_no_reset: assert property (@(posedge clock) disable iff (!rstn)
        sevt_mode && !match && wt_run && wt != 16'hffff |=> wt != 16'h0000)
        else $error("timer reset without live match");
    a_conv_follows_trig: assert property (@(posedge clock) disable iff (!rstn)
        sevt_rise && aux_reg[`CCPW_AUX_CONV_EN] |=> conv_start ##1 !conv_start)
        else $error("conversion start missing or long");
    a_no_ovf_on_trig: assert property (@(posedge clock) disable iff (!rstn)
        trig_reset && !irq_flags_reg[`CCPW_FLAG_OVF] && !wr[4] |=> !irq_flags_reg[`CCPW_FLAG_OVF])
        else $error("trigger set overflow flag");
    a_unit_flag_set: assert property (@(posedge clock) disable iff (!rstn)
        sevt_rise |=> irq_flags_reg[`CCPW_FLAG_UNIT])
        else $error("trigger did not raise unit flag");
    a_pin_left_port: assert property (@(posedge clock) disable iff (!rstn)
        sevt_mode && $past(sevt_mode) |-> !pin_drive && !unit_output_pin)
        else $error("pin driven in trigger mode");
    a_period_restart: assert property (@(posedge clock) disable iff (!rstn)
        period_hit && pwm_mode && duty_next != 10'h000 |=> pt_count_reg == 8'h00 && unit_output_pin)
        else $error("period match did not restart cycle");
    a_duty_latched: assert property (@(posedge clock) disable iff (!rstn)
        period_hit && pwm_mode |=> duty_buf == $past(duty_next))
        else $error("duty not latched at period match");
    a_duty_held: assert property (@(posedge clock) disable iff (!rstn)
        pwm_mode && !period_hit |=> $stable(duty_buf))
        else $error("duty buffer changed mid period");
    a_pin_cleared: assert property (@(posedge clock) disable iff (!rstn)
        pwm_mode && !period_hit && time_base == duty_buf |=> !unit_output_pin)
        else $error("pin not cleared at duty match");
endmodule
`default_nettype wire

// ===== dv/ccpw_load.sv
// Load and converter model at the far side of the unit
`default_nettype none
module ccpw_load (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Pin and converter
    input  wire logic unit_output_pin,
    input  wire logic pin_drive,
    input  wire logic conv_start,
    // Measurements
    output logic      pin_level,
    output var int    conv_count,
    output var int    conv_gap,
    output var int    high_len,
    output var int    per_len
);
    logic level_q;
    int   since_rise;
    int   since_conv;

    // Pin direction set to input outside PWM, so the pull-down wins
    assign pin_level = pin_drive ? unit_output_pin : 1'b0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_q    <= 1'b0;
            since_rise <= 0;
            since_conv <= 0;
            conv_count <= 0;
            conv_gap   <= 0;
            high_len   <= 0;
            per_len    <= 0;
        end else begin
            level_q    <= pin_level;
            since_rise <= since_rise + 1;
            since_conv <= since_conv + 1;
            if (pin_level && !level_q) begin
                per_len    <= since_rise;
                since_rise <= 1;
            end
            if (!pin_level && level_q) begin
                high_len <= since_rise;
            end
            // Converter accepts every start at once
            if (conv_start) begin
                conv_count <= conv_count + 1;
                conv_gap   <= since_conv;
                since_conv <= 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the compare trigger and PWM unit
`include "ccpw_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, unit_output_pin, pin_drive;
    logic        special_event, conv_start, pin_level;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          conv_count, conv_gap, high_len, per_len, failures, compares;

    ccpw_unit ccpw_unit_i (.clock(clock), .rstn(rstn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .unit_output_pin(unit_output_pin), .pin_drive(pin_drive),
        .special_event(special_event), .conv_start(conv_start));
    ccpw_load ccpw_load_i (.clock(clock), .rstn(rstn), .unit_output_pin(unit_output_pin),
        .pin_drive(pin_drive), .conv_start(conv_start), .pin_level(pin_level),
        .conv_count(conv_count), .conv_gap(conv_gap), .high_len(high_len), .per_len(per_len));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_data({31'h0, got}, {31'h0, exp});
    endtask

    task automatic chk_cnt(input int got, input int exp);
        chk_data(got, exp);
    endtask

    // Address and data go up together and drop only after the take edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = `CCPW_RESP_OKAY);
        int n;
        n = 0;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        bready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!(awready && wready) && n < 50);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (!bvalid && n < 100);
        if (n >= 100) failures++;
        chk_data({30'h0, bresp}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = `CCPW_RESP_OKAY);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (!rvalid && n < 100);
        if (n >= 100) failures++;
        chk_data({30'h0, rresp}, {30'h0, r});
        if (r == `CCPW_RESP_OKAY) chk_data(rdata, {24'h0, d});
    endtask

    task automatic wait_sev(input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (special_event !== lvl && n < 200);
        if (special_event !== lvl) failures++;
    endtask

    task automatic wait_conv(input int target);
        int n;
        n = 0;
        while (conv_count < target && n < 500) begin
            @(posedge clock);
            n++;
        end
        if (conv_count < target) failures++;
    endtask

    task automatic count_high(input int len, output int h);
        h = 0;
        repeat (len) begin
            @(posedge clock);
            if (pin_level === 1'b1) h++;
        end
    endtask

    task automatic t_reset();
        rd(`CCPW_OFF_CONTROL, `CCPW_RST_CONTROL);
        rd(`CCPW_OFF_PERIOD, `CCPW_RST_PERIOD);
        rd(`CCPW_OFF_PT_COUNT, `CCPW_RST_PT_COUNT);
        rd(8'h2c, 8'h00, `CCPW_RESP_SLVERR);
        wr(8'h2c, 8'h5a, `CCPW_RESP_SLVERR);
    endtask

    task automatic t_trigger();
        int c;
        wr(`CCPW_OFF_WT_LOW, 8'h00);
        wr(`CCPW_OFF_WT_HIGH, 8'h00);
        wr(`CCPW_OFF_DUTY_LOW, 8'h05);
        wr(`CCPW_OFF_DUTY_HIGH, 8'h00);
        wr(`CCPW_OFF_IRQ_FLAGS, 8'h00);
        wr(`CCPW_OFF_CONTROL, {4'h0, `CCPW_MODE_SEVT});
        wr(`CCPW_OFF_AUX, 8'h03);
        wait_sev(1'b1);
        chk_bit(pin_drive, 1'b0);
        @(posedge clock);
        chk_bit(conv_start, 1'b1);
        wait_conv(3);
        chk_cnt(conv_gap, 24);
        rd(`CCPW_OFF_IRQ_FLAGS, 8'h04);
        // Converter off: matches still reset the timer but start nothing
        wr(`CCPW_OFF_AUX, 8'h01);
        // A start launched at the take edge is counted one clock later
        @(posedge clock);
        c = conv_count;
        repeat (60) @(posedge clock);
        chk_cnt(conv_count, c);
        wr(`CCPW_OFF_AUX, 8'h03);
    endtask

    task automatic t_cancel();
        int c;
        wait_sev(1'b0);
        wait_sev(1'b1);
        c = conv_count;
        wr(`CCPW_OFF_DUTY_LOW, 8'h07);
        wait_conv(c + 2);
        chk_cnt(conv_gap, 8);
        wait_conv(c + 3);
        chk_cnt(conv_gap, 32);
    endtask

    task automatic t_pwm();
        int s;
        int h;
        wr(`CCPW_OFF_AUX, 8'h00);
        wr(`CCPW_OFF_PERIOD, 8'h03);
        wr(`CCPW_OFF_DUTY_LOW, 8'h01);
        wr(`CCPW_OFF_CONTROL, 8'h2c);
        chk_bit(pin_drive, 1'b1);
        for (int i = 0; i < 3; i++) begin
            s = 1 << (2 * i);
            wr(`CCPW_OFF_PT_CONTROL, 8'h04 + 8'(i));
            repeat (48 * s) @(posedge clock);
            chk_cnt(per_len, 16 * s);
            chk_cnt(high_len, 6 * s);
        end
        wr(`CCPW_OFF_DUTY_HIGH, 8'h55);
        rd(`CCPW_OFF_DUTY_HIGH, 8'h01);
        wr(`CCPW_OFF_PT_CONTROL, 8'h04);
        wr(`CCPW_OFF_CONTROL, 8'h1c);
        repeat (48) @(posedge clock);
        chk_cnt(high_len, 5);
        wr(`CCPW_OFF_DUTY_LOW, 8'h05);
        repeat (48) @(posedge clock);
        count_high(32, h);
        chk_cnt(h, 32);
        wr(`CCPW_OFF_DUTY_LOW, 8'h00);
        wr(`CCPW_OFF_CONTROL, 8'h0c);
        repeat (48) @(posedge clock);
        count_high(32, h);
        chk_cnt(h, 0);
        // Duty beyond the period keeps the pin high, so leaving PWM must pull it low
        wr(`CCPW_OFF_DUTY_LOW, 8'h05);
        repeat (48) @(posedge clock);
        wr(`CCPW_OFF_CONTROL, 8'h00);
        @(posedge clock);
        chk_bit(pin_drive, 1'b0);
        chk_bit(unit_output_pin, 1'b0);
    endtask

    initial begin
        failures = 0;
        compares = 0;
        rstn     = 1'b0;
        awvalid  = 1'b0;
        wvalid   = 1'b0;
        awaddr   = 8'h00;
        wdata    = 32'h0;
        wstrb    = 4'hf;
        bready   = 1'b0;
        arvalid  = 1'b0;
        araddr   = 8'h00;
        rready   = 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_trigger();
        t_cancel();
        t_pwm();
        close_out();
    end

    // The whole run needs under 4000 cycles, so this only cuts a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
